// ### logic/tsn_params.svh
`ifndef TSN_PARAMS_SVH
`define TSN_PARAMS_SVH
`define TSN_NUM_SW       8
`define TSN_WORD_W       16
`define TSN_ADDR_W       16
`define TSN_BIT_W        4
`define TSN_IDX_W        10
`define TSN_BCD_W        12
`define TSN_PADDR_W      12
`define TSN_CTRL_OFS     12'h000
`define TSN_CMD_OFS      12'h004
`define TSN_STAT_OFS     12'h008
`define TSN_NBASE_OFS    12'h00C
`define TSN_LAMP_OFS     12'h010
`define TSN_VAL_OFS      12'h014
`define TSN_CFG_OFS      12'h040
`define TSN_LADR_OFS     12'h080
`define TSN_SLOT_HI      11
`define TSN_SLOT_LO      5
`define TSN_CTRL_WORD    0
`define TSN_CTRL_POLL    1
`define TSN_CMD_SCREEN   0
`define TSN_CFG_MODE_LO  0
`define TSN_CFG_MODE_HI  1
`define TSN_CFG_FLASH    2
`define TSN_CFG_EN       3
`define TSN_CFG_BIT_LO   4
`define TSN_CFG_BIT_HI   7
`define TSN_CFG_WORD_LO  8
`define TSN_CFG_WORD_HI  23
`define TSN_LADR_WORD_HI 15
`define TSN_LADR_BIT_LO  16
`define TSN_LADR_BIT_HI  19
`define TSN_IDX_WORD_OFS 16'h0001
`define TSN_STB_WORD_OFS 16'h0002
`define TSN_STB_BIT      4'hB
`define TSN_CTRL_RST     2'h0
`define TSN_CFG_RST      24'h000000
`define TSN_LADR_RST     20'h00000
`define TSN_NBASE_RST    16'h0000
`define TSN_BLINK_MS     500
`define TSN_CLK_MHZ      100
`endif

// ### logic/tsn_pkg.sv
`include "tsn_params.svh"
package tsn_pkg;
    typedef enum logic [1:0] {
        MODE_MOMENTARY = 2'h0,
        MODE_ALTERNATE = 2'h1,
        MODE_SET       = 2'h2,
        MODE_RESET     = 2'h3
    } notify_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_IDX     = 3'h1,
        ST_STB_SET = 3'h3,
        ST_STB_CLR = 3'h2,
        ST_NOTIFY  = 3'h6,
        ST_SNAP    = 3'h7,
        ST_LAMP    = 3'h5
    } state_t;

    typedef logic [`TSN_WORD_W-1:0] word_t;
    typedef logic [`TSN_ADDR_W-1:0] waddr_t;
    typedef logic [`TSN_BIT_W-1:0]  bidx_t;
endpackage : tsn_pkg

// ### logic/touch_switch_bit_notifier.sv
`include "tsn_params.svh"
`timescale 1ns/10ps
`default_nettype none
module touch_switch_bit_notifier #(
    parameter int BLINK_CYCLES = `TSN_BLINK_MS * 1000 * `TSN_CLK_MHZ
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`TSN_PADDR_W-1:0]   paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [`TSN_NUM_SW-1:0]    touch_press,
    input  wire logic                      entry_valid,
    input  wire logic [`TSN_IDX_W-1:0]     entry_index,
    output logic                           hm_req,
    output logic                           hm_we,
    output logic                           hm_bit_only,
    output logic      [`TSN_ADDR_W-1:0]    hm_word,
    output logic      [`TSN_BIT_W-1:0]     hm_bit,
    output logic      [`TSN_WORD_W-1:0]    hm_wdata,
    input  wire logic                      hm_ack,
    input  wire logic [`TSN_WORD_W-1:0]    hm_rdata,
    output logic      [`TSN_NUM_SW-1:0]    sw_lit
);
    localparam int N = `TSN_NUM_SW;
    localparam int SW = $clog2(N);

    function automatic logic [SW-1:0] first_set(input logic [N-1:0] v);
        first_set = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = SW'(i);
            end
        end
    endfunction : first_set

    function automatic tsn_pkg::word_t put_bit(input tsn_pkg::word_t w,
                                               input tsn_pkg::bidx_t b,
                                               input logic v);
        put_bit = w;
        put_bit[b] = v;
    endfunction : put_bit

    // Double dabble; entries above 999 wrap in the top digit.
    function automatic logic [`TSN_BCD_W-1:0] to_bcd(
            input logic [`TSN_IDX_W-1:0] b);
        logic [`TSN_BCD_W+`TSN_IDX_W-1:0] s;
        s = {{`TSN_BCD_W{1'b0}}, b};
        for (int i = 0; i < `TSN_IDX_W; i++) begin
            for (int d = 0; d < 3; d++) begin
                if (s[`TSN_IDX_W+4*d +: 4] > 4'h4) begin
                    s[`TSN_IDX_W+4*d +: 4] = s[`TSN_IDX_W+4*d +: 4] + 4'h3;
                end
            end
            s = s << 1;
        end
        to_bcd = s[`TSN_IDX_W +: `TSN_BCD_W];
    endfunction : to_bcd

    // Configuration and state.
    logic [1:0]                  ctrl_q;
    tsn_pkg::waddr_t             nbase_q;
    logic [`TSN_CFG_WORD_HI:0]   cfg_q  [N];
    logic [`TSN_LADR_BIT_HI:0]   ladr_q [N];
    tsn_pkg::word_t              shadow_q [N];
    logic [N-1:0]                sync1_q, sync2_q, held_q;
    logic [N-1:0]                value_q, pend_q, snap_q, lamp_q;
    logic                        entry_pend_q;
    logic [`TSN_IDX_W-1:0]       entry_idx_q;
    logic [`TSN_BCD_W-1:0]       work_bcd_q;
    tsn_pkg::state_t             state_q;
    logic [SW-1:0]               cur_q, lamp_ptr_q;
    logic [31:0]                 blink_cnt_q;
    logic                        blink_q;
    logic                        screen_cmd;
    logic                        wr_en, rd_en;
    logic                        word_unit;
    logic                        issue_notify, issue_snap, done;
    logic [SW-1:0]               pick, snap_pick;
    logic [N-1:0]                mom, en;

    assign word_unit = ctrl_q[`TSN_CTRL_WORD];
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && !pready;
    assign screen_cmd = wr_en && paddr == `TSN_CMD_OFS
                        && pwdata[`TSN_CMD_SCREEN];
    assign pick = first_set(pend_q);
    assign snap_pick = first_set(snap_q);
    assign done = hm_req && hm_ack;
    assign issue_notify = state_q == tsn_pkg::ST_IDLE && !entry_pend_q
                          && |pend_q;
    assign issue_snap = state_q == tsn_pkg::ST_IDLE && !entry_pend_q
                        && !(|pend_q) && |snap_q;

    generate
        for (genvar g = 0; g < N; g++) begin : g_sw
            assign mom[g] = cfg_q[g][`TSN_CFG_MODE_HI:`TSN_CFG_MODE_LO]
                            == tsn_pkg::MODE_MOMENTARY;
            assign en[g] = cfg_q[g][`TSN_CFG_EN];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sw_lit[g] <= 1'b0;
                end else begin
                    // Steady or blinking highlight from the lamp bit.
                    sw_lit[g] <= en[g] && lamp_q[g]
                        && (!cfg_q[g][`TSN_CFG_FLASH] || blink_q);
                end
            end
        end
    endgenerate

    // Touch panel pins are asynchronous to pclk.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            held_q  <= '0;
        end else begin
            sync1_q <= touch_press;
            sync2_q <= sync1_q;
            held_q  <= sync2_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q >= 32'(BLINK_CYCLES - 1)) begin
            blink_cnt_q <= '0;
            blink_q     <= !blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    // APB slave: one wait state, so prdata and pready leave flip-flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (rd_en) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
            prdata  <= '0;
            unique case (paddr)
                `TSN_CTRL_OFS:  prdata <= {30'h0, ctrl_q};
                `TSN_CMD_OFS:   prdata <= '0;
                `TSN_STAT_OFS:  prdata <= {16'h0, 8'(pend_q), 5'h0,
                                           |snap_q, entry_pend_q,
                                           state_q != tsn_pkg::ST_IDLE};
                `TSN_NBASE_OFS: prdata <= {16'h0, nbase_q};
                `TSN_LAMP_OFS:  prdata <= 32'(lamp_q);
                `TSN_VAL_OFS:   prdata <= 32'(value_q);
                default: begin
                    if (paddr[`TSN_SLOT_HI:`TSN_SLOT_LO]
                        == `TSN_CFG_OFS >> `TSN_SLOT_LO) begin
                        prdata <= 32'(cfg_q[paddr[SW+1:2]]);
                    end else if (paddr[`TSN_SLOT_HI:`TSN_SLOT_LO]
                                 == `TSN_LADR_OFS >> `TSN_SLOT_LO) begin
                        prdata <= 32'(ladr_q[paddr[SW+1:2]]);
                    end else begin
                        pslverr <= 1'b1;
                    end
                end
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= `TSN_CTRL_RST;
            nbase_q <= `TSN_NBASE_RST;
            for (int i = 0; i < N; i++) begin
                cfg_q[i]  <= `TSN_CFG_RST;
                ladr_q[i] <= `TSN_LADR_RST;
            end
        end else if (wr_en && !pslverr) begin
            if (paddr == `TSN_CTRL_OFS) begin
                ctrl_q <= pwdata[1:0];
            end
            if (paddr == `TSN_NBASE_OFS) begin
                nbase_q <= pwdata[`TSN_ADDR_W-1:0];
            end
            if (paddr[`TSN_SLOT_HI:`TSN_SLOT_LO]
                == `TSN_CFG_OFS >> `TSN_SLOT_LO) begin
                cfg_q[paddr[SW+1:2]] <= pwdata[`TSN_CFG_WORD_HI:0];
            end
            if (paddr[`TSN_SLOT_HI:`TSN_SLOT_LO]
                == `TSN_LADR_OFS >> `TSN_SLOT_LO) begin
                ladr_q[paddr[SW+1:2]] <= pwdata[`TSN_LADR_BIT_HI:0];
            end
        end
    end

    // Press events and screen changes; a new event beats the clear
    // that the write engine gives in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= '0;
            pend_q  <= '0;
            snap_q  <= '0;
        end else begin
            if (issue_notify) begin
                pend_q[pick] <= 1'b0;
            end
            if (issue_snap) begin
                snap_q[snap_pick] <= 1'b0;
            end
            if (state_q == tsn_pkg::ST_SNAP && done && !mom[cur_q]) begin
                value_q[cur_q] <= hm_rdata[cfg_q[cur_q][`TSN_CFG_BIT_HI:
                                                        `TSN_CFG_BIT_LO]];
            end
            for (int i = 0; i < N; i++) begin
                if (screen_cmd) begin
                    snap_q[i] <= en[i];
                    if (en[i] && mom[i] && value_q[i]) begin
                        value_q[i] <= 1'b0;
                        pend_q[i]  <= 1'b1;
                    end
                end else if (en[i] && sync2_q[i] != held_q[i]) begin
                    unique case (tsn_pkg::notify_mode_t'(
                            cfg_q[i][`TSN_CFG_MODE_HI:`TSN_CFG_MODE_LO]))
                        tsn_pkg::MODE_MOMENTARY: begin
                            value_q[i] <= sync2_q[i];
                            pend_q[i]  <= 1'b1;
                        end
                        tsn_pkg::MODE_ALTERNATE: begin
                            if (sync2_q[i]) begin
                                value_q[i] <= !value_q[i];
                                pend_q[i]  <= 1'b1;
                            end
                        end
                        tsn_pkg::MODE_SET: begin
                            if (sync2_q[i]) begin
                                value_q[i] <= 1'b1;
                                pend_q[i]  <= 1'b1;
                            end
                        end
                        tsn_pkg::MODE_RESET: begin
                            if (sync2_q[i]) begin
                                value_q[i] <= 1'b0;
                                pend_q[i]  <= 1'b1;
                            end
                        end
                    endcase
                end
            end
        end
    end

    // Word-unit copies; every switch sharing the written word follows,
    // which is safe only while the host keeps one mode per word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < N; i++) begin
                shadow_q[i] <= '0;
            end
        end else if (state_q == tsn_pkg::ST_SNAP && done) begin
            shadow_q[cur_q] <= hm_rdata;
        end else if (issue_notify && word_unit && !mom[pick]) begin
            for (int i = 0; i < N; i++) begin
                if (cfg_q[i][`TSN_CFG_WORD_HI:`TSN_CFG_WORD_LO]
                    == cfg_q[pick][`TSN_CFG_WORD_HI:`TSN_CFG_WORD_LO]) begin
                    shadow_q[i] <= put_bit(shadow_q[pick],
                        cfg_q[pick][`TSN_CFG_BIT_HI:`TSN_CFG_BIT_LO],
                        value_q[pick]);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_pend_q <= 1'b0;
            entry_idx_q  <= '0;
        end else if (entry_valid) begin
            entry_pend_q <= 1'b1;
            entry_idx_q  <= entry_index;
        end else if (state_q == tsn_pkg::ST_IDLE) begin
            entry_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_q <= '0;
        end else if (state_q == tsn_pkg::ST_LAMP && done) begin
            lamp_q[lamp_ptr_q] <= hm_rdata[ladr_q[lamp_ptr_q]
                [`TSN_LADR_BIT_HI:`TSN_LADR_BIT_LO]];
        end
    end

    // Host memory engine: one request outstanding, held until acked.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= tsn_pkg::ST_IDLE;
            hm_req      <= 1'b0;
            hm_we       <= 1'b0;
            hm_bit_only <= 1'b0;
            hm_word     <= '0;
            hm_bit      <= '0;
            hm_wdata    <= '0;
            cur_q       <= '0;
            lamp_ptr_q  <= '0;
            work_bcd_q  <= '0;
        end else begin
            unique case (state_q)
                tsn_pkg::ST_IDLE: begin
                    if (entry_pend_q) begin
                        hm_req      <= 1'b1;
                        hm_we       <= 1'b1;
                        hm_bit_only <= 1'b0;
                        hm_word     <= nbase_q + `TSN_IDX_WORD_OFS;
                        hm_wdata    <= 16'(to_bcd(entry_idx_q));
                        work_bcd_q  <= to_bcd(entry_idx_q);
                        state_q     <= tsn_pkg::ST_IDX;
                    end else if (issue_notify) begin
                        cur_q       <= pick;
                        hm_req      <= 1'b1;
                        hm_we       <= 1'b1;
                        hm_word     <= cfg_q[pick][`TSN_CFG_WORD_HI:
                                                   `TSN_CFG_WORD_LO];
                        hm_bit      <= cfg_q[pick][`TSN_CFG_BIT_HI:
                                                   `TSN_CFG_BIT_LO];
                        hm_bit_only <= !word_unit;
                        if (!word_unit) begin
                            hm_wdata <= put_bit('0, cfg_q[pick][
                                `TSN_CFG_BIT_HI:`TSN_CFG_BIT_LO],
                                value_q[pick]);
                        end else if (mom[pick]) begin
                            hm_wdata <= put_bit('0, cfg_q[pick][
                                `TSN_CFG_BIT_HI:`TSN_CFG_BIT_LO],
                                value_q[pick]);
                        end else begin
                            hm_wdata <= put_bit(shadow_q[pick],
                                cfg_q[pick][`TSN_CFG_BIT_HI:
                                            `TSN_CFG_BIT_LO],
                                value_q[pick]);
                        end
                        state_q <= tsn_pkg::ST_NOTIFY;
                    end else if (issue_snap) begin
                        cur_q       <= snap_pick;
                        hm_req      <= 1'b1;
                        hm_we       <= 1'b0;
                        hm_bit_only <= 1'b0;
                        hm_word     <= cfg_q[snap_pick][`TSN_CFG_WORD_HI:
                                                        `TSN_CFG_WORD_LO];
                        state_q     <= tsn_pkg::ST_SNAP;
                    end else if (ctrl_q[`TSN_CTRL_POLL]) begin
                        hm_req      <= 1'b1;
                        hm_we       <= 1'b0;
                        hm_bit_only <= 1'b0;
                        hm_word     <= ladr_q[lamp_ptr_q][
                                       `TSN_LADR_WORD_HI:0];
                        state_q     <= tsn_pkg::ST_LAMP;
                    end
                end
                tsn_pkg::ST_IDX: begin
                    if (done) begin
                        // The index is delivered before the strobe rises.
                        hm_bit_only <= 1'b1;
                        hm_word     <= nbase_q + `TSN_STB_WORD_OFS;
                        hm_bit      <= `TSN_STB_BIT;
                        hm_wdata    <= put_bit('0, `TSN_STB_BIT, 1'b1);
                        state_q     <= tsn_pkg::ST_STB_SET;
                    end
                end
                tsn_pkg::ST_STB_SET: begin
                    if (done) begin
                        hm_wdata <= '0;
                        state_q  <= tsn_pkg::ST_STB_CLR;
                    end
                end
                tsn_pkg::ST_STB_CLR, tsn_pkg::ST_NOTIFY,
                tsn_pkg::ST_SNAP: begin
                    if (done) begin
                        hm_req  <= 1'b0;
                        state_q <= tsn_pkg::ST_IDLE;
                    end
                end
                tsn_pkg::ST_LAMP: begin
                    if (done) begin
                        hm_req     <= 1'b0;
                        lamp_ptr_q <= lamp_ptr_q + SW'(1);
                        state_q    <= tsn_pkg::ST_IDLE;
                    end
                end
                default: begin
                    hm_req  <= 1'b0;
                    state_q <= tsn_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule : touch_switch_bit_notifier
`default_nettype wire

// ### verification/tsn_checker.sv
`include "tsn_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tsn_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        entry_valid,
    input wire logic [9:0]  entry_index,
    input wire logic        hm_req,
    input wire logic        hm_we,
    input wire logic        hm_bit_only,
    input wire logic [15:0] hm_word,
    input wire logic [3:0]  hm_bit,
    input wire logic [15:0] hm_wdata,
    input wire logic        hm_ack
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    function automatic logic [15:0] bcd(input logic [9:0] v);
        return {4'h0, 4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction : bcd
    a_req_hold: assert property (hm_req && !hm_ack |=> hm_req &&
        $stable({hm_we, hm_bit_only, hm_word, hm_bit, hm_wdata}))
        else $error("host request dropped or changed before ack");
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_err_hole: assert property (pready && paddr inside {[12'h018:12'h03C]}
        |-> pslverr) else $error("unmapped access not flagged");
    a_err_ready: assert property (pslverr |-> pready && paddr >= 12'h018)
        else $error("error flag outside an unmapped access");
    a_cmd_zero: assert property (pready && !pwrite && paddr == 12'h004
        |-> prdata == 32'h0) else $error("command register not read as 0");
    a_entry_index: assert property (
        entry_valid && !hm_req |-> ##2 hm_req && hm_we && !hm_bit_only
        && hm_wdata == bcd($past(entry_index, 2)))
        else $error("entry index not written first in decimal");
    a_strobe_pulse: assert property (hm_req && hm_ack && hm_bit_only &&
        hm_bit == 4'hB && hm_wdata == 16'h0800 |=> hm_req && hm_bit == 4'hB
        && hm_wdata == 16'h0000) else $error("strobe not cleared after set");
    c_entry: cover property (entry_valid && !hm_req);
    c_bit_write: cover property (hm_req && hm_ack && hm_bit_only);
    c_unmapped: cover property (pslverr);
endmodule : tsn_checker
bind touch_switch_bit_notifier tsn_checker u_chk (.*);
`default_nettype wire

// ### verification/host_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_mem_model #(parameter int NBASE = 16) (
    input  wire logic        pclk,
    input  wire logic        hm_req,
    input  wire logic        hm_we,
    input  wire logic        hm_bit_only,
    input  wire logic [15:0] hm_word,
    input  wire logic [3:0]  hm_bit,
    input  wire logic [15:0] hm_wdata,
    output logic             hm_ack,
    output logic      [15:0] hm_rdata,
    output logic      [15:0] seen_idx
);
    logic [15:0] mem [256];
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        hm_ack = 1'b0;
        hm_rdata = 16'h0000;
        seen_idx = 16'h0000;
    end
    // Latency is random so both prompt and slow answers occur.
    always @(posedge pclk) begin
        hm_ack <= 1'b0;
        hm_rdata <= ~hm_rdata;
        if (hm_req && !hm_ack && $urandom_range(0, 2) == 0) begin
            hm_ack <= 1'b1;
            if (!hm_we) hm_rdata <= mem[hm_word[7:0]];
            else if (!hm_bit_only) mem[hm_word[7:0]] <= hm_wdata;
            else mem[hm_word[7:0]][hm_bit] <= hm_wdata[hm_bit];
            if (hm_we && hm_bit_only && hm_word == 16'(NBASE + 2) &&
                hm_bit == 4'hB && hm_wdata[11] && !mem[NBASE + 2][11])
                seen_idx <= mem[NBASE + 1];
        end
    end
endmodule : host_mem_model
`default_nettype wire

// ### verification/touch_switch_bit_notifier_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t %s", $time, m); end end
module touch_switch_bit_notifier_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, entry_valid = 0, e, hm_req, hm_we, hm_bit_only;
    logic hm_ack;
    logic [7:0] touch_press = 8'h00, sw_lit;
    logic [9:0] entry_index = 10'h000;
    logic [15:0] hm_word, hm_wdata, hm_rdata, seen_idx, w, s;
    logic [3:0] hm_bit;
    int n_fail = 0, n_tests = 0, cyc = 0, bt[6] = '{3, 5, 7, 15, 2, 9};
    touch_switch_bit_notifier #(.BLINK_CYCLES(4)) u_dut (.*);
    host_mem_model #(.NBASE(16)) u_host (.*);
    always #5 pclk = ~pclk;
    task automatic end_sim;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    always @(posedge pclk) if (++cyc == 30000) begin n_fail++; end_sim(); end
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; e = pslverr; psel <= 0; penable <= 0;
    endtask : apb
    task automatic settle;
        int q = 0;
        while (q < 12) begin @(posedge pclk); q = hm_req ? 0 : q + 1; end
    endtask : settle
    task automatic tap(input int i, input logic v);
        touch_press[i] <= v;
        settle();
    endtask : tap
    function automatic logic [15:0] bcd(input int v);
        return 16'((v / 100) << 8 | (v / 10 % 10) << 4 | v % 10);
    endfunction : bcd
    initial begin
        void'($urandom(75));
        repeat (16) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h00C, 0); `CHK(r, 32'h0, "base reset value")
        apb(0, 12'h004, 0); `CHK(r, 32'h0, "command reads zero")
        apb(0, 12'h020, 0); `CHK(e, 1'b1, "unmapped error")
        apb(1, 12'h00C, 16);
        for (int i = 0; i < 6; i++)
            apb(1, 12'h040 + 12'(4 * i),
                (32 + i) << 8 | bt[i] << 4 | 8 | i % 4);
        for (int i = 0; i < 4; i++) u_host.mem[32 + i] = 16'($urandom());
        // The screen copy gives the toggle switch its starting value.
        apb(1, 12'h004, 1); settle();
        for (int i = 0; i < 4; i++) begin
            w = u_host.mem[32 + i];
            for (int k = 0; k < 2; k++) begin
                tap(i, 1);
                w[bt[i]] = i == 0 ? 1'b1 : i == 1 ? ~w[bt[i]] : i == 2;
                `CHK(u_host.mem[32 + i], w, "press result")
                tap(i, 0);
                if (i == 0) w[3] = 0;
                `CHK(u_host.mem[32 + i], w, "release result")
            end
        end
        apb(1, 12'h000, 1);
        u_host.mem[36] = 16'($urandom()) | 16'h0004;
        tap(4, 1); `CHK(u_host.mem[36], 16'h0004, "word momentary")
        s = 16'($urandom());
        u_host.mem[37] = s;
        apb(1, 12'h004, 1); settle();
        `CHK(u_host.mem[36], 16'h0000, "held switch on screen change")
        u_host.mem[37] = s ^ 16'hF0F0;
        tap(5, 1); `CHK(u_host.mem[37], s ^ 16'h0200, "word from copy")
        tap(5, 0); tap(4, 0);
        for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            entry_index <= k == 0 ? 10'd999 : 10'($urandom_range(0, 999));
            entry_valid <= 1;
            @(posedge pclk);
            entry_valid <= 0;
            settle();
            `CHK(u_host.mem[17], bcd(entry_index), "entry index")
            `CHK(seen_idx, bcd(entry_index), "index at strobe")
            `CHK(u_host.mem[18][11], 1'b0, "strobe cleared")
        end
        apb(1, 12'h080, 32'h40030);
        u_host.mem[48] = 16'h0010;
        apb(1, 12'h000, 2);
        for (int t = 0; t < 300 && sw_lit[0] !== 1'b1; t++) @(posedge pclk);
        `CHK(sw_lit[0], 1'b1, "lamp lit steady")
        apb(1, 12'h040, 32'h0000203C);
        for (int t = 0; t < 20 && sw_lit[0] !== 1'b0; t++) @(posedge pclk);
        `CHK(sw_lit[0], 1'b0, "flash dark phase")
        for (int t = 0; t < 20 && sw_lit[0] !== 1'b1; t++) @(posedge pclk);
        `CHK(sw_lit[0], 1'b1, "flash lit phase")
        apb(1, 12'h040, 32'h00002038);
        u_host.mem[48] = 16'h0000;
        for (int t = 0; t < 300 && sw_lit[0] !== 1'b0; t++) @(posedge pclk);
        `CHK(sw_lit[0], 1'b0, "lamp unlit")
        end_sim();
    end
endmodule : touch_switch_bit_notifier_tb
`default_nettype wire
